// ==== design/xpt_host.sv ====
// The implementer's own choices: the address map and register access over APB.
`default_nettype none
// Overview of operation
// [RULE1] device keeps two seven-bit connection stages for each of 17 outputs
// [RULE2] outputs follow only the second stage, not first-stage writes
// [RULE3] five-bit output address, bit four most significant
// [RULE4] word bits five to zero pick one of 33 inputs
// [RULE5] word bit six enables the output, clear means high impedance
// [RULE6] chip select and write strobe low load first stage of addressed output
// [RULE7] host raises write strobe again after every write
// [RULE8] chip select and transfer low copy all first stage to second
// [RULE9] first stage undefined at power-up; host writes all before transfer
// [RULE10] chip select and readback low drive addressed second-stage word
// [RULE11] host releases data bus whenever readback strobe is low
// [RULE12] readback and write strobes may be low together
// [RULE13] strobes, address and data ignored unless chip select low
// [RULE14] raising chip select changes no stored word nor outputs
// [RULE15] output disable low clears enable bit of all second-stage words
// [RULE16] output disable acts regardless of chip select
// [RULE17] output disable leaves first stage and input selects untouched
// [RULE18] host pulses output disable low at power-up
// [RULE19] all control inputs act on level, not edge
// [RULE20] address 10001 writes the word into every first-stage latch
// [RULE21] unused input codes mean no connection; unused addresses ignored
module xpt_host (
  input  wire logic        clk,               // 100 MHz clock
  input  wire logic        resetn,            // async reset, low
  input  wire logic        psel,              // apb select
  input  wire logic        penable,           // apb access phase
  input  wire logic        pwrite,            // apb direction
  input  wire logic [7:0]  paddr,             // apb byte address
  input  wire logic [31:0] pwdata,            // apb write data
  output logic [31:0]      prdata,            // apb read data
  output logic             pready,            // apb ready
  output logic             pslverr,           // apb error
  output logic             chip_sel_n,        // device chip select
  output logic             pend_write_n,      // first-stage write strobe
  output logic             transfer_n,        // second-stage transfer
  output logic             readback_strobe_n, // readback enable
  output logic             out_disable_n,     // global output disable
  output logic [4:0]       out_addr,          // output address pins
  output logic [6:0]       data_o,            // data pins, driven value
  output logic             data_oe,           // data pins driven
  input  wire logic [6:0]  data_i             // data pins, sensed value
);
  typedef struct packed {
    xpt_host_pkg::phase_t ph;
    xpt_host_pkg::cmd_t   cmd;
    logic                 pend;
    logic [4:0]           addr;
    logic [6:0]           data;
    logic [6:0]           rdbk;
    logic [16:0]          written;
    logic                 booted, refused;
    logic [4:0]           shsel;
    logic                 cs_n, we_n, up_n, rd_n, dis_n;
    logic [4:0]           pin_a;
    logic [6:0]           pin_d;
    logic                 d_oe;
    logic                 pready;
    logic [31:0]          prdata;
    logic                 pslverr;
  } st_t;

  localparam st_t ST_RST = '{
    ph: xpt_host_pkg::PH_IDLE, cmd: xpt_host_pkg::CMD_DISABLE,
    pend: 1'b1, addr: xpt_host_pkg::RST_ADDR,
    data: xpt_host_pkg::RST_DATA, rdbk: xpt_host_pkg::RST_WORD,
    written: 17'h00000, booted: 1'b0, refused: 1'b0, shsel: 5'h00,
    cs_n: 1'b1, we_n: 1'b1, up_n: 1'b1, rd_n: 1'b1, dis_n: 1'b1,
    pin_a: xpt_host_pkg::RST_ADDR, pin_d: xpt_host_pkg::RST_DATA,
    d_oe: 1'b0, pready: 1'b0, prdata: 32'h00000000, pslverr: 1'b0};
  localparam logic [16:0] ALL_WR = 17'h1FFFF;
  localparam int          CNT_W  = xpt_host_pkg::CNT_W;
  st_t q;
  st_t d;
  logic                            tm_load;
  logic [CNT_W-1:0]                tm_count;
  logic                            tm_exp;
  logic                            access, commit, busy, ok;
  shadow_if sh ();
  phase_timer #(.W(CNT_W)) u_timer (
    .clk     (clk),
    .resetn  (resetn),
    .load    (tm_load),
    .count   (tm_count),
    .expired (tm_exp)
  );
  shadow_mem #(.N(xpt_host_pkg::NUM_OUT)) u_shadow (
    .clk    (clk),
    .resetn (resetn),
    .port   (sh.mem)
  );

  assign access = psel && penable;
  assign commit = access && q.pready && pwrite;
  assign busy   = (q.ph != xpt_host_pkg::PH_IDLE) || q.pend;
  assign sh.raddr = q.shsel;

  // ------------------------------------------------------------------
  // bus slave and pin sequencer
  // ------------------------------------------------------------------
  always_comb
  begin
    d = q;
    ok = 1'b0;
    tm_load = 1'b0;
    tm_count = '0;
    sh.wr = 1'b0;
    sh.wr_all = 1'b0;
    sh.waddr = q.pin_a;
    sh.wdata = q.pin_d;
    d.pready = access && !q.pready;
    if (access && !q.pready)
    begin
      d.pslverr = 1'b0;
      d.prdata = 32'h00000000;
      case (paddr)
        xpt_host_pkg::OFF_CMD:      d.prdata[2:0] = q.cmd;
        xpt_host_pkg::OFF_ADDR:     d.prdata[4:0] = q.addr;
        xpt_host_pkg::OFF_DATA:     d.prdata[6:0] = q.data;
        xpt_host_pkg::OFF_STATUS:
        begin
          d.prdata[xpt_host_pkg::ST_BUSY]    = busy;
          d.prdata[xpt_host_pkg::ST_BOOTED]  = q.booted;
          d.prdata[xpt_host_pkg::ST_ALL_WR]  = &q.written;
          d.prdata[xpt_host_pkg::ST_REFUSED] = q.refused;
        end
        xpt_host_pkg::OFF_READBACK: d.prdata[6:0] = q.rdbk;
        xpt_host_pkg::OFF_WRITTEN:  d.prdata[16:0] = q.written;
        xpt_host_pkg::OFF_SHSEL:    d.prdata[4:0] = q.shsel;
        xpt_host_pkg::OFF_SHDATA:   d.prdata[6:0] = sh.rdata;
        default:                    d.pslverr = 1'b1;
      endcase
    end
    if (commit)
    begin
      case (paddr)
        xpt_host_pkg::OFF_ADDR:  d.addr = pwdata[4:0];
        xpt_host_pkg::OFF_DATA:  d.data = pwdata[6:0];
        xpt_host_pkg::OFF_SHSEL: d.shsel = pwdata[4:0];
        xpt_host_pkg::OFF_STATUS:
          if (pwdata[xpt_host_pkg::ST_REFUSED])
            d.refused = 1'b0;
        xpt_host_pkg::OFF_CMD:
        begin
          case (xpt_host_pkg::cmd_t'(pwdata[2:0]))
            xpt_host_pkg::CMD_WRITE:
              ok = q.addr <= xpt_host_pkg::BCAST_ADDR;          // [RULE21]
            xpt_host_pkg::CMD_READ:
              ok = q.addr <= xpt_host_pkg::LAST_ADDR;           // [RULE21]
            xpt_host_pkg::CMD_UPDATE:  ok = &q.written;         // [RULE9]
            xpt_host_pkg::CMD_DISABLE: ok = 1'b1;
            default:                   ok = 1'b0;
          endcase
          // one command at a time; a refused one leaves a sticky flag
          if (ok && !busy)
          begin
            d.pend = 1'b1;
            d.cmd = xpt_host_pkg::cmd_t'(pwdata[2:0]);
          end
          else
            d.refused = 1'b1;
        end
        default: ;
      endcase
    end
    case (q.ph)
      xpt_host_pkg::PH_IDLE:
        if (q.pend)
        begin
          d.pend = 1'b0;
          tm_load = 1'b1;
          if (q.cmd == xpt_host_pkg::CMD_DISABLE)
          begin
            // no chip select needed for the disable pulse
            d.dis_n = 1'b0;                                     // [RULE16]
            d.ph = xpt_host_pkg::PH_STROBE;
            tm_count = CNT_W'(xpt_host_pkg::C_TW - 1);          // [RULE15]
          end
          else
          begin
            d.cs_n = 1'b0;                                      // [RULE13]
            d.pin_a = q.addr;                                   // [RULE3]
            d.ph = xpt_host_pkg::PH_SETUP;
            case (q.cmd)
              xpt_host_pkg::CMD_WRITE:
              begin
                d.pin_d = q.data;                               // [RULE4]
                d.d_oe = 1'b1;
                tm_count = CNT_W'(xpt_host_pkg::C_DSW - 1);
              end
              xpt_host_pkg::CMD_READ:
                tm_count = CNT_W'(xpt_host_pkg::C_RHA - 1);
              default:
                tm_count = CNT_W'(xpt_host_pkg::C_WHU - 1);
            endcase
          end
        end
      xpt_host_pkg::PH_SETUP:
        if (tm_exp)
        begin
          tm_load = 1'b1;
          d.ph = xpt_host_pkg::PH_STROBE;
          case (q.cmd)
            xpt_host_pkg::CMD_WRITE:
            begin
              d.we_n = 1'b0;                                    // [RULE6]
              tm_count = CNT_W'(xpt_host_pkg::C_WP - 1);
            end
            xpt_host_pkg::CMD_READ:
            begin
              d.rd_n = 1'b0;                                    // [RULE10]
              d.d_oe = 1'b0;                                    // [RULE11]
              tm_count = CNT_W'(xpt_host_pkg::C_RDE - 1);
            end
            default:
            begin
              d.up_n = 1'b0;                                    // [RULE8]
              tm_count = CNT_W'(xpt_host_pkg::C_UW - 1);
            end
          endcase
        end
      xpt_host_pkg::PH_STROBE:
        if (tm_exp)
        begin
          // strobes are level acting, so each is dropped before moving on
          d.we_n = 1'b1;                                        // [RULE7]
          d.up_n = 1'b1;                                        // [RULE19]
          d.rd_n = 1'b1;
          d.dis_n = 1'b1;
          tm_load = 1'b1;
          d.ph = xpt_host_pkg::PH_HOLD;
          case (q.cmd)
            xpt_host_pkg::CMD_WRITE:
            begin
              if (q.pin_a == xpt_host_pkg::BCAST_ADDR)
              begin
                sh.wr_all = 1'b1;                               // [RULE20]
                d.written = ALL_WR;
              end
              else
              begin
                sh.wr = 1'b1;
                d.written[q.pin_a] = 1'b1;                      // [RULE1]
              end
            end
            xpt_host_pkg::CMD_READ:
            begin
              d.rdbk = data_i;                                  // [RULE10]
              // the device may still drive the pins for a while
              tm_count = CNT_W'(xpt_host_pkg::C_RDD - 1);       // [RULE11]
            end
            xpt_host_pkg::CMD_DISABLE: d.booted = 1'b1;         // [RULE18]
            default: ;
          endcase
        end
      xpt_host_pkg::PH_HOLD:
        if (tm_exp)
        begin
          d.cs_n = 1'b1;                                        // [RULE14]
          d.d_oe = 1'b0;
          d.ph = xpt_host_pkg::PH_IDLE;
        end
      default: d.ph = xpt_host_pkg::PH_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      q <= ST_RST;
    else
      q <= d;
  end

  assign prdata            = q.prdata;
  assign pready            = q.pready;
  assign pslverr           = q.pslverr;
  assign chip_sel_n        = q.cs_n;
  assign pend_write_n      = q.we_n;
  assign transfer_n        = q.up_n;
  assign readback_strobe_n = q.rd_n;
  assign out_disable_n     = q.dis_n;
  assign out_addr          = q.pin_a;
  assign data_o            = q.pin_d;
  assign data_oe           = q.d_oe;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_write_pulse;
    !pend_write_n [*2] ##1 pend_write_n;
  endsequence
  property p_write_released;
    $fell(pend_write_n) |-> s_write_pulse;
  endproperty
  a_write_released: assert property (p_write_released) // [RULE7]
    else $error("write strobe not returned high after two cycles");
  property p_write_setup;
    $fell(pend_write_n) |-> data_oe && $past(data_oe, 2) && !chip_sel_n;
  endproperty
  a_write_setup: assert property (p_write_setup) // [RULE6]
    else $error("write strobe without data setup or chip select");
  property p_bus_free_read;
    !readback_strobe_n |-> !data_oe;
  endproperty
  a_bus_free_read: assert property (p_bus_free_read) // [RULE11]
    else $error("host drives data during readback");
  property p_bus_release_gap;
    $rose(readback_strobe_n) |-> !data_oe [*3];
  endproperty
  a_bus_release_gap: assert property (p_bus_release_gap) // [RULE11]
    else $error("data driven too soon after readback");
  property p_update_after_all;
    $fell(transfer_n) |-> &q.written;
  endproperty
  a_update_after_all: assert property (p_update_after_all) // [RULE9]
    else $error("transfer before every output was written");
  // sampled resetn keeps the release edge itself out of the antecedent
  property p_boot_disable;
    resetn && !q.booted && q.ph == xpt_host_pkg::PH_IDLE
      |-> ##1 !out_disable_n ##1 !out_disable_n ##1 out_disable_n;
  endproperty
  a_boot_disable: assert property (p_boot_disable) // [RULE18]
    else $error("power-up disable pulse missing or wrong width");
  property p_strobe_under_cs;
    !(pend_write_n && transfer_n && readback_strobe_n) |-> !chip_sel_n;
  endproperty
  a_strobe_under_cs: assert property (p_strobe_under_cs) // [RULE13]
    else $error("strobe asserted without chip select");
  property p_update_width;
    $fell(transfer_n) |-> !transfer_n [*2] ##1 transfer_n;
  endproperty
  a_update_width: assert property (p_update_width) // [RULE8]
    else $error("transfer pulse not two cycles");
endmodule : xpt_host
`default_nettype wire

// ==== design/xpt_host_pkg.sv ====
`default_nettype none
package xpt_host_pkg;

  // ------------------------------------------------------------------
  // connection store geometry
  // ------------------------------------------------------------------
  localparam int NUM_OUT = 17;
  localparam int ADDR_W  = 5;
  localparam int WORD_W  = 7;
  localparam int EN_BIT  = 6;
  localparam int CNT_W   = 4;
  localparam logic [4:0] BCAST_ADDR = 5'h11;
  localparam logic [4:0] LAST_ADDR  = 5'h10;

  // ------------------------------------------------------------------
  // register offsets and fields
  // ------------------------------------------------------------------
  localparam logic [7:0] OFF_CMD      = 8'h00;
  localparam logic [7:0] OFF_ADDR     = 8'h04;
  localparam logic [7:0] OFF_DATA     = 8'h08;
  localparam logic [7:0] OFF_STATUS   = 8'h0C;
  localparam logic [7:0] OFF_READBACK = 8'h10;
  localparam logic [7:0] OFF_WRITTEN  = 8'h14;
  localparam logic [7:0] OFF_SHSEL    = 8'h18;
  localparam logic [7:0] OFF_SHDATA   = 8'h1C;
  localparam int ST_BUSY    = 0;
  localparam int ST_BOOTED  = 1;
  localparam int ST_ALL_WR  = 2;
  localparam int ST_REFUSED = 3;
  localparam logic [4:0]  RST_ADDR = 5'h00;
  localparam logic [6:0]  RST_DATA = 7'h00;
  localparam logic [6:0]  RST_WORD = 7'h00;

  typedef enum logic [2:0] {
    CMD_NONE    = 3'h0,
    CMD_WRITE   = 3'h1,
    CMD_UPDATE  = 3'h2,
    CMD_READ    = 3'h3,
    CMD_DISABLE = 3'h4
  } cmd_t;

  typedef enum logic [1:0] {
    PH_IDLE   = 2'h0,
    PH_SETUP  = 2'h1,
    PH_STROBE = 2'h3,
    PH_HOLD   = 2'h2
  } phase_t;

  // ------------------------------------------------------------------
  // pin timing, ns and cycles
  // ------------------------------------------------------------------
  localparam int CLK_NS   = 10;
  localparam int T_DSW_NS = 15;
  localparam int T_WP_NS  = 15;
  localparam int T_WHU_NS = 10;
  localparam int T_UW_NS  = 15;
  localparam int T_TW_NS  = 15;
  localparam int T_RHA_NS = 5;
  localparam int T_RDE_NS = 15;
  localparam int T_RDD_NS = 30;
  localparam int C_DSW = (T_DSW_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_WP  = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_WHU = (T_WHU_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_UW  = (T_UW_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_TW  = (T_TW_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_RHA = (T_RHA_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_RDE = (T_RDE_NS + CLK_NS - 1) / CLK_NS;
  localparam int C_RDD = (T_RDD_NS + CLK_NS - 1) / CLK_NS;

endpackage : xpt_host_pkg
`default_nettype wire

// ==== design/shadow_if.sv ====
`default_nettype none
interface shadow_if;
  logic       wr;
  logic       wr_all;
  logic [4:0] waddr;
  logic [6:0] wdata;
  logic [4:0] raddr;
  logic [6:0] rdata;
  modport ctrl (output wr, output wr_all, output waddr, output wdata,
                output raddr, input rdata);
  modport mem  (input wr, input wr_all, input waddr, input wdata,
                input raddr, output rdata);
endinterface : shadow_if
`default_nettype wire

// ==== design/phase_timer.sv ====
`default_nettype none
module phase_timer #(
  parameter int W = 4
) (
  input  wire logic         clk,     // system clock
  input  wire logic         resetn,  // async reset, low
  input  wire logic         load,    // start a new phase
  input  wire logic [W-1:0] count,   // phase length minus one
  output logic              expired  // phase has run out
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } tm_t;

  tm_t q;
  tm_t d;

  always_comb
  begin
    d = q;
    if (load)
      d.cnt = count;
    else if (q.cnt != '0)
      d.cnt = q.cnt - W'(1);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      q <= '0;
    else
      q <= d;
  end

  assign expired = (q.cnt == '0);
endmodule : phase_timer
`default_nettype wire

// ==== design/shadow_mem.sv ====
`default_nettype none
module shadow_mem #(
  parameter int N = 17
) (
  input  wire logic clk,     // system clock
  input  wire logic resetn,  // async reset, low
  shadow_if.mem     port     // write and read port
);
  typedef struct packed {
    logic [N-1:0][6:0] word;
    logic [6:0]        rdata;
  } mem_t;

  mem_t q;
  mem_t d;
  logic [N-1:0][6:0] nxt;

  for (genvar g = 0; g < N; g++)
  begin : g_word
    assign nxt[g] = (port.wr_all || (port.wr && port.waddr == 5'(g)))
                    ? port.wdata : q.word[g];
  end

  always_comb
  begin
    d = q;
    d.word = nxt;
    d.rdata = (int'(port.raddr) < N) ? q.word[port.raddr] : 7'h00;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      q <= '0;
    else
      q <= d;
  end

  assign port.rdata = q.rdata;
endmodule : shadow_mem
`default_nettype wire

// ==== testbench/xpt_dev_model.sv ====
`default_nettype none
module xpt_dev_model #(
  parameter int RD_DELAY_NS = 15  // readback driver turn-on and release lag
) (
  input  wire logic       chip_sel_n,        // chip select, low
  input  wire logic       pend_write_n,      // first-stage write strobe
  input  wire logic       transfer_n,        // rank transfer strobe
  input  wire logic       readback_strobe_n, // readback enable
  input  wire logic       out_disable_n,     // global output disable
  input  wire logic [4:0] out_addr,          // output address
  input  wire logic [6:0] data_in,           // resolved data bus
  output logic [6:0]      read_data,         // readback value
  output logic            read_oe            // readback drivers on
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------------
  // two latch ranks, bit six enable, bits five..zero input number
  // ------------------------------------------------------------------
  logic [6:0] pending_connection_word [17];
  logic [6:0] active_connection_word  [17];
  logic       rb_on;

  // first rank left unknown at power-up, so an early transfer shows up
  always @*
  begin
    if (!chip_sel_n && !pend_write_n)
    begin
      if (out_addr == xpt_host_pkg::BCAST_ADDR)
        for (int i = 0; i < 17; i++)
          pending_connection_word[i] = data_in;
      else if (out_addr <= xpt_host_pkg::LAST_ADDR)
        pending_connection_word[out_addr] = data_in;
    end
    if (!chip_sel_n && !transfer_n)
      for (int i = 0; i < 17; i++)
        active_connection_word[i] = pending_connection_word[i];
    if (!out_disable_n)
      for (int i = 0; i < 17; i++)
        active_connection_word[i][6] = 1'b0;
  end

  // ------------------------------------------------------------------
  // readback drivers, slow on purpose
  // ------------------------------------------------------------------
  assign rb_on = !chip_sel_n && !readback_strobe_n;
  assign #(RD_DELAY_NS) read_oe = rb_on;
  assign #(RD_DELAY_NS) read_data = (out_addr <= xpt_host_pkg::LAST_ADDR) ?
                                    active_connection_word[out_addr] : 7'h00;
endmodule : xpt_dev_model
`default_nettype wire

// ==== testbench/xpt_host_bench.sv ====
`default_nettype none
module xpt_host_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, resetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        cs_n, we_n, tr_n, rb_n, dis_n, data_oe, dev_oe, err;
  logic [4:0]  out_addr;
  logic [6:0]  data_o, dev_d, bus, bus_last, w;
  int          fails, tests_run, cycles, seed, r;
  int          exp_pend [17];
  int          exp_act  [17];
  logic [2:0]  bad_cmd [3] = '{3'h1, 3'h3, 3'h5};
  logic [4:0]  bad_adr [3] = '{5'h12, 5'h11, 5'h00};

  xpt_host u_dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chip_sel_n(cs_n),
    .pend_write_n(we_n), .transfer_n(tr_n), .readback_strobe_n(rb_n),
    .out_disable_n(dis_n), .out_addr(out_addr), .data_o(data_o),
    .data_oe(data_oe), .data_i(bus));
  xpt_dev_model u_dev (.chip_sel_n(cs_n), .pend_write_n(we_n),
    .transfer_n(tr_n), .readback_strobe_n(rb_n), .out_disable_n(dis_n),
    .out_addr(out_addr), .data_in(bus), .read_data(dev_d), .read_oe(dev_oe));

  // released bus floats: show the inverse of the last driven value
  always @*
  begin
    if (data_oe === 1'b1)
      bus = data_o;
    else if (dev_oe === 1'b1)
      bus = dev_d;
    else
      bus = ~bus_last;
  end

  always @(posedge clk)
  begin
    if (data_oe === 1'b1 || dev_oe === 1'b1)
      bus_last <= bus;
    if (resetn && rb_n === 1'b0)
      check("host_off_bus", data_oe, 32'h0);
    if (resetn && dis_n === 1'b0)
      check("disable_no_cs", cs_n, 32'h1);
    cycles++;
    if (cycles == 30000)
    begin
      fails++;
      print_verdict();
    end
  end

  always #5 clk = ~clk;

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // read before the slave's own update at this edge; timeout ends a hang
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_st(input int b, input logic v);
    do
      apb(1'b0, xpt_host_pkg::OFF_STATUS, 32'h0);
    while (rd[b] !== v);
  endtask : wait_st

  task automatic cmd(input logic [2:0] c, input logic [4:0] a,
                     input logic [6:0] d);
    apb(1'b1, xpt_host_pkg::OFF_ADDR, {27'h0, a});
    apb(1'b1, xpt_host_pkg::OFF_DATA, {25'h0, d});
    apb(1'b1, xpt_host_pkg::OFF_CMD, {29'h0, c});
    wait_st(xpt_host_pkg::ST_BUSY, 1'b0);
  endtask : cmd

  task automatic cmp_all();
    for (int i = 0; i < 17; i++)
    begin
      check("pend", u_dev.pending_connection_word[i], exp_pend[i]);
      check("active", u_dev.active_connection_word[i], exp_act[i]);
    end
  endtask : cmp_all

  task automatic print_verdict();
    if (fails == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict

  initial
  begin
    {clk, psel, penable, pwrite, paddr, pwdata, bus_last} = '0;
    {fails, tests_run, cycles} = '0;
    seed = 67703;
    resetn = 1'b0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    wait_st(xpt_host_pkg::ST_BOOTED, 1'b1);
    for (int i = 0; i < 17; i++)
      check("boot_off", u_dev.active_connection_word[i][6], 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check("unmapped_err", err, 32'h1);
    check("unmapped_data", rd, 32'h0);
    // transfer before every row is written must be held back
    cmd(3'h2, 5'h00, 7'h00);
    wait_st(xpt_host_pkg::ST_REFUSED, 1'b1);
    check("early_update", rd[xpt_host_pkg::ST_REFUSED], 32'h1);
    apb(1'b1, xpt_host_pkg::OFF_STATUS, 32'h8);
    for (int i = 0; i < 17; i++)
    begin
      r = $random(seed);
      w = {r[7], 6'(r[15:8] % 33)};
      cmd(3'h1, 5'(i), w);
      exp_pend[i] = w;
      check("boot_off", u_dev.active_connection_word[i][6], 32'h0);
    end
    check("strobe_idle", {cs_n, we_n}, 32'h3);
    apb(1'b0, xpt_host_pkg::OFF_WRITTEN, 32'h0);
    check("written", rd, 32'h1FFFF);
    apb(1'b1, xpt_host_pkg::OFF_SHSEL, 32'h5);
    apb(1'b0, xpt_host_pkg::OFF_SHDATA, 32'h0);
    check("shadow", rd, exp_pend[5]);
    for (int k = 0; k < 2; k++)
    begin
      cmd(3'h2, 5'h00, 7'h00);
      exp_act = exp_pend;
      cmp_all();
      for (int i = 0; i < 17; i++)
      begin
        cmd(3'h3, 5'(i), 7'h00);
        apb(1'b0, xpt_host_pkg::OFF_READBACK, 32'h0);
        check("readback", rd, exp_act[i]);
      end
      // each pass ends with one word to every row at once
      r = $random(seed);
      w = {r[3], 6'(r[15:8] % 33)};
      cmd(3'h1, xpt_host_pkg::BCAST_ADDR, w);
      for (int i = 0; i < 17; i++)
        exp_pend[i] = w;
      cmp_all();
    end
    for (int k = 0; k < 3; k++)
    begin
      cmd(bad_cmd[k], bad_adr[k], 7'h7F);
      wait_st(xpt_host_pkg::ST_REFUSED, 1'b1);
      check("refused", rd[xpt_host_pkg::ST_REFUSED], 32'h1);
      apb(1'b1, xpt_host_pkg::OFF_STATUS, 32'h8);
      cmp_all();
    end
    cmd(3'h4, 5'h00, 7'h00);
    check("disable_no_cs", cs_n, 32'h1);
    for (int i = 0; i < 17; i++)
      exp_act[i] = exp_act[i] & 32'h3F;
    cmp_all();
    cmd(3'h3, 5'h04, 7'h00);
    apb(1'b0, xpt_host_pkg::OFF_READBACK, 32'h0);
    check("readback_off", rd, exp_act[4]);
    print_verdict();
  end
endmodule : xpt_host_bench
`default_nettype wire
